// ### design/ssp_device.sv
// sensor end of the two-wire serial port with its small register file
// assumes the host makes sclk and keeps the gaps between commands
//
// Overview of operation
// - only the host starts any transfer
// - host makes serial clock, device only receives
// - one shared half-duplex data line
// - write: direction 1, address, then data
// - read: direction 0, address, device returns data
// - host changes data on falling clock edges
// - device samples data on rising edges
// - host releases data line after address
// - host waits 100 us before read data
// - device holds last bit until next fall
// - after write device leaves line undriven
// - no traffic while power down high
// - power down pulse releases device driver
// - 100 us between consecutive writes
// - 100 us between write and following read
// - 120 ns after read before next command
// - parameters writable, motion readable
// - power down also resynchronises port
// - stalled transaction resets port after timeout
// - power down resets port, keeps registers
// - unmapped writes ignored, unmapped reads zero
// - device drives only after address rising edge
`timescale 1ns/1ps
module ssp_device
    import ssp_pkg::*;
#(
    parameter int TXN_TIMEOUT = TXN_TIMEOUT_CYC,
    parameter logic [7:0] PRODUCT_ID = 8'h5A // arbitrary value
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    ssp_if.dev link,
    input wire logic [7:0] motion_x_i,
    input wire logic [7:0] motion_y_i,
    output logic [PARAM_NUM*DATA_W-1:0] param_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic port_rst_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] cmd_q;
    logic [7:0] wdata_q;
    logic [EV_NUM-1:0] ev_tgl_q;
    logic sdo_q;
    logic sdo_oe_q;
    logic [7:0] rd_data_q;
    logic [EV_NUM-1:0] ev_s1_q;
    logic [EV_NUM-1:0] ev_s2_q;
    logic [EV_NUM-1:0] ev_s3_q;
    logic [EV_NUM-1:0] ev_pulse;
    logic pd_s1_q;
    logic pd_s2_q;
    logic busy_q;
    logic timeout_q;
    logic [TIMER_W-1:0] timer_q;
    logic [7:0] params_q [PARAM_NUM];

    // ------------------------------------------------------------
    // link side: receive shifter on rising sclk
    // ------------------------------------------------------------
    // the port reset comes from a system-domain flop; sclk is quiet
    // while it is raised, so its release does not race a clock edge
    always_ff @(posedge link.sclk or posedge port_rst_q) begin
        if (port_rst_q) begin
            bit_cnt_q <= 5'h00;
        end else if (bit_cnt_q == BITS_FRAME) begin
            bit_cnt_q <= 5'h01;
        end else begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge link.sclk or posedge port_rst_q) begin
        if (port_rst_q) begin
            cmd_q <= 8'h00;
            wdata_q <= 8'h00;
        end else if (bit_cnt_q < BITS_ADDR || bit_cnt_q == BITS_FRAME) begin
            cmd_q <= {cmd_q[6:0], link.sdio};
        end else if (cmd_q[7] == DIR_WRITE) begin
            wdata_q <= {wdata_q[6:0], link.sdio};
        end
    end

    // toggles survive a port reset so that a reset never looks like an event
    always_ff @(posedge link.sclk or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ev_tgl_q <= '0;
        end else begin
            if (bit_cnt_q == 5'h00 || bit_cnt_q == BITS_FRAME) begin
                ev_tgl_q[EV_START] <= ~ev_tgl_q[EV_START];
            end
            if (bit_cnt_q == BITS_LAST_ADDR && cmd_q[6] == DIR_READ) begin
                ev_tgl_q[EV_READ] <= ~ev_tgl_q[EV_READ];
            end
            if (bit_cnt_q == BITS_LAST) begin
                ev_tgl_q[EV_DONE] <= ~ev_tgl_q[EV_DONE];
                if (cmd_q[7] == DIR_WRITE) begin
                    ev_tgl_q[EV_WRITE] <= ~ev_tgl_q[EV_WRITE];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // link side: data driver on falling sclk
    // ------------------------------------------------------------
    // read data is fetched in the system domain long before this edge,
    // since the host must pause after the address; it is quasi-static here
    always_ff @(negedge link.sclk or posedge port_rst_q) begin
        if (port_rst_q) begin
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (bit_cnt_q >= BITS_ADDR && bit_cnt_q < BITS_FRAME && cmd_q[7] == DIR_READ) begin
            sdo_oe_q <= 1'b1;
            sdo_q <= rd_data_q[3'(BITS_LAST - bit_cnt_q)];
        end else begin
            sdo_oe_q <= 1'b0;
            sdo_q <= 1'b0;
        end
    end

    assign link.sdio_dev_o = sdo_q;
    assign link.sdio_dev_oe = sdo_oe_q;

    // ------------------------------------------------------------
    // system side: crossings
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_s3_q <= '0;
        end else begin
            ev_s1_q <= ev_tgl_q;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end

    assign ev_pulse = ev_s2_q ^ ev_s3_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
        end else begin
            pd_s1_q <= link.power_down_pin;
            pd_s2_q <= pd_s1_q;
        end
    end

    // ------------------------------------------------------------
    // system side: transaction timer and port reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            timer_q <= '0;
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= 1'b0;
            if (pd_s2_q) begin
                busy_q <= 1'b0;
            end else if (ev_pulse[EV_START]) begin
                busy_q <= 1'b1;
                timer_q <= '0;
            end else if (ev_pulse[EV_DONE]) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                if (timer_q == TIMER_W'(TXN_TIMEOUT - 1)) begin
                    busy_q <= 1'b0;
                    timeout_q <= 1'b1;
                end else begin
                    timer_q <= timer_q + 1'b1;
                end
            end
        end
    end

    // power down resets only the port; registers below are untouched
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_rst_q <= 1'b1;
        end else begin
            port_rst_q <= pd_s2_q | timeout_q;
        end
    end

    // ------------------------------------------------------------
    // system side: register file
    // ------------------------------------------------------------
    // cmd_q and wdata_q are stable here: the host may not clock the next
    // frame far enough to disturb them before the gap has run out
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_q <= 8'h00;
        end else if (ev_pulse[EV_READ]) begin
            if (cmd_q[6:0] == ADDR_PRODUCT) begin
                rd_data_q <= PRODUCT_ID;
            end else if (cmd_q[6:0] == ADDR_MOTION_X) begin
                rd_data_q <= motion_x_i;
            end else if (cmd_q[6:0] == ADDR_MOTION_Y) begin
                rd_data_q <= motion_y_i;
            end else if (cmd_q[6:0] >= ADDR_PARAM_BASE && cmd_q[6:0] < ADDR_PARAM_BASE + 7'(PARAM_NUM)) begin
                rd_data_q <= params_q[2'(cmd_q[6:0] - ADDR_PARAM_BASE)];
            end else begin
                rd_data_q <= UNMAPPED_READ;
            end
        end
    end

    for (genvar g = 0; g < PARAM_NUM; g++) begin : g_param
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                params_q[g] <= PARAM_RESET;
            end else if (ev_pulse[EV_WRITE] && cmd_q[6:0] == ADDR_PARAM_BASE + 7'(g)) begin
                params_q[g] <= wdata_q;
            end
        end
        assign param_o[g*DATA_W +: DATA_W] = params_q[g];
    end

endmodule

// ### design/ssp_host.sv
// host end: runs read and write frames and power down pulses
// assumes one request at a time, taken while req_ready_o is high
`timescale 1ns/1ps
module ssp_host
    import ssp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    ssp_if.host link,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [6:0] req_addr_i,
    input wire logic [7:0] req_data_i,
    input wire logic resync_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o
);

    typedef enum logic [5:0] {
        H_IDLE = 6'b000001,
        H_LOW = 6'b000010,
        H_HIGH = 6'b000100,
        H_PREP = 6'b001000,
        H_GAP = 6'b010000,
        H_PD = 6'b100000
    } ssp_hstate_type;

    ssp_hstate_type state_q;
    logic [HOST_TIMER_W-1:0] timer_q;
    logic [3:0] bit_q;
    logic [15:0] shift_q;
    logic write_q;
    logic [7:0] rd_q;
    logic sclk_q;
    logic sdo_q;
    logic oe_q;
    logic pd_q;
    logic ready_q;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic sdio_s1_q;
    logic sdio_s2_q;

    // ------------------------------------------------------------
    // data line input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sdio_s1_q <= 1'b1;
            sdio_s2_q <= 1'b1;
        end else begin
            sdio_s1_q <= link.sdio;
            sdio_s2_q <= sdio_s1_q;
        end
    end

    // ------------------------------------------------------------
    // frame sequencer; sclk is divided down from clk_sys_i
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= H_IDLE;
            timer_q <= '0;
            bit_q <= 4'h0;
            shift_q <= 16'h0000;
            write_q <= 1'b0;
            rd_q <= 8'h00;
            sclk_q <= 1'b1;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            pd_q <= 1'b0;
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
        end else begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    ready_q <= 1'b1;
                    if (resync_i) begin
                        state_q <= H_PD;
                        pd_q <= 1'b1;
                        oe_q <= 1'b0;
                        ready_q <= 1'b0;
                        timer_q <= HOST_TIMER_W'(PD_PULSE_CYC - 1);
                    end else if (req_valid_i && ready_q) begin
                        state_q <= H_LOW;
                        shift_q <= {req_write_i, req_addr_i, req_data_i};
                        write_q <= req_write_i;
                        bit_q <= 4'h0;
                        sclk_q <= 1'b0;
                        sdo_q <= req_write_i;
                        oe_q <= 1'b1;
                        ready_q <= 1'b0;
                        timer_q <= HOST_TIMER_W'(SCLK_HALF_CYC - 1);
                    end
                end
                H_LOW: begin
                    if (timer_q == '0) begin
                        state_q <= H_HIGH;
                        sclk_q <= 1'b1;
                        timer_q <= HOST_TIMER_W'(SCLK_HALF_CYC - 1);
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                H_HIGH: begin
                    if (timer_q == '0) begin
                        shift_q <= {shift_q[14:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                        if (!write_q && bit_q >= 4'(BITS_ADDR)) begin
                            rd_q <= {rd_q[6:0], sdio_s2_q};
                        end
                        if (bit_q == 4'(BITS_LAST)) begin
                            state_q <= H_GAP;
                            oe_q <= 1'b0;
                            rsp_valid_q <= 1'b1;
                            rsp_data_q <= write_q ? 8'h00 : {rd_q[6:0], sdio_s2_q};
                            timer_q <= write_q ? HOST_TIMER_W'(WRITE_GAP_CYC - 1) : HOST_TIMER_W'(READ_GAP_CYC - 1);
                        end else if (bit_q == 4'(BITS_LAST_ADDR) && !write_q) begin
                            state_q <= H_PREP;
                            oe_q <= 1'b0;
                            timer_q <= HOST_TIMER_W'(READ_PREP_CYC - 1);
                        end else begin
                            state_q <= H_LOW;
                            sclk_q <= 1'b0;
                            sdo_q <= shift_q[14];
                            timer_q <= HOST_TIMER_W'(SCLK_HALF_CYC - 1);
                        end
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                H_PREP: begin
                    if (timer_q == '0) begin
                        state_q <= H_LOW;
                        sclk_q <= 1'b0;
                        timer_q <= HOST_TIMER_W'(SCLK_HALF_CYC - 1);
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                H_GAP: begin
                    if (timer_q == '0) begin
                        state_q <= H_IDLE;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                H_PD: begin
                    // no frame is started while the pin is high
                    if (timer_q == '0) begin
                        state_q <= H_IDLE;
                        pd_q <= 1'b0;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.sdio_host_o = sdo_q;
    assign link.sdio_host_oe = oe_q;
    assign link.power_down_pin = pd_q;
    assign req_ready_o = ready_q;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;

endmodule

// ### design/ssp_if.sv
// link wires between the host end and the sensor end
// the shared data line is resolved here; an idle line reads high (pull-up)
`timescale 1ns/1ps
interface ssp_if;
    logic sclk;
    logic power_down_pin;
    logic sdio_host_o;
    logic sdio_host_oe;
    logic sdio_dev_o;
    logic sdio_dev_oe;
    logic sdio;

    assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);

    modport dev (
        input sclk,
        input power_down_pin,
        input sdio,
        output sdio_dev_o,
        output sdio_dev_oe
    );

    modport host (
        output sclk,
        output power_down_pin,
        output sdio_host_o,
        output sdio_host_oe,
        input sdio
    );
endinterface

// ### design/ssp_pkg.sv
// shared constants for both ends of the sensor serial port
// assumes a 10 MHz system clock on both ends
package ssp_pkg;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic DIR_READ = 1'b0;
    localparam logic [4:0] BITS_LAST_ADDR = 5'h07;
    localparam logic [4:0] BITS_ADDR = 5'h08;
    localparam logic [4:0] BITS_LAST = 5'h0F;
    localparam logic [4:0] BITS_FRAME = 5'h10;

    // ------------------------------------------------------------
    // device register map
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_PRODUCT = 7'h00;
    localparam logic [6:0] ADDR_MOTION_X = 7'h02;
    localparam logic [6:0] ADDR_MOTION_Y = 7'h03;
    localparam logic [6:0] ADDR_PARAM_BASE = 7'h10;
    localparam int PARAM_NUM = 4;
    localparam logic [7:0] PARAM_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // crossing events, one toggle each
    // ------------------------------------------------------------
    localparam int EV_START = 0;
    localparam int EV_READ = 1;
    localparam int EV_WRITE = 2;
    localparam int EV_DONE = 3;
    localparam int EV_NUM = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int READ_PREP_US = 100;
    localparam int WRITE_GAP_US = 100;
    localparam int PD_PULSE_US = 100;
    localparam int READ_GAP_NS = 120;
    localparam int SCLK_HALF_NS = 500;
    localparam int TXN_TIMEOUT_MS = 900;
    localparam int READ_PREP_CYC = (READ_PREP_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int WRITE_GAP_CYC = (WRITE_GAP_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int PD_PULSE_CYC = (PD_PULSE_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int READ_GAP_CYC = (READ_GAP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / SYS_CLK_PERIOD_NS;
    localparam int TXN_TIMEOUT_CYC = TXN_TIMEOUT_MS * (1000000 / SYS_CLK_PERIOD_NS);
    localparam int TIMER_W = 24;
    localparam int HOST_TIMER_W = 16;

endpackage

// ### tb/ssp_chk.sv
// link checker: watches the wires between the host end and the sensor end
// assumes both ends run on the one system clock and reset given here
`timescale 1ns/1ps
module ssp_chk
    import ssp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sclk,
    input wire logic power_down_pin,
    input wire logic sdio_host_o,
    input wire logic sdio_host_oe,
    input wire logic sdio_dev_o,
    input wire logic sdio_dev_oe
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    // ----------------------------------------------------------------
    // helper: saturating count of cycles with sclk high
    // ----------------------------------------------------------------
    logic [11:0] hi_cnt_q;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hi_cnt_q <= 12'h000;
        end else if (!sclk) begin
            hi_cnt_q <= 12'h000;
        end else if (hi_cnt_q != 12'hFFF) begin
            hi_cnt_q <= hi_cnt_q + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_no_bus_fight: assert property (!(sdio_host_oe && sdio_dev_oe))
        else $error("both ends drive the data line");
    a_host_data_fall: assert property (sdio_host_oe && $past(sdio_host_oe) && $changed(sdio_host_o) |-> $fell(sclk))
        else $error("host data changed away from a falling clock");
    a_pd_dev_quiet: assert property (power_down_pin [*6] |-> !sdio_dev_oe)
        else $error("device still drives during power down");
    a_pd_no_traffic: assert property (power_down_pin |-> sclk && !sdio_host_oe)
        else $error("traffic while power down is high");
    a_drive_after_fall: assert property ($rose(sdio_dev_oe) |-> !sclk && $past(sclk))
        else $error("device began driving off the falling edge");
    a_release_on_fall: assert property ($fell(sdio_dev_oe) |-> !sclk || power_down_pin)
        else $error("device released the line early");
    a_hold_while_high: assert property (sdio_dev_oe && sclk && $past(sclk) |-> $stable(sdio_dev_o))
        else $error("device data moved while clock high");
    a_read_prep_pause: assert property ($rose(sdio_dev_oe) |-> $past(hi_cnt_q) >= READ_PREP_CYC - 5)
        else $error("read data clock came without the pause");
    a_host_release_high: assert property ($fell(sdio_host_oe) |-> sclk)
        else $error("host released the line with clock low");
    a_frame_driven: assert property (!sclk |-> sdio_host_oe || sdio_dev_oe)
        else $error("clock low with nobody driving data");
endmodule

// ### tb/tb_sensor_serial_port.sv
// bench: host end and sensor end on one link, plus a second sensor end
// whose link the bench drives by hand to break the host's rules
`timescale 1ns/1ps
module tb_sensor_serial_port;
    import ssp_pkg::*;
    localparam int TMO = 2000;
    localparam logic [7:0] PID = 8'h3C; // arbitrary value
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic req_valid_i = 1'b0, req_write_i = 1'b0, resync_i = 1'b0, req_ready_o, rsp_valid_o;
    logic [6:0] req_addr_i = 7'h00;
    logic [7:0] req_data_i = 8'h00, mx = 8'hC3, my = 8'h1E, rsp_data_o;
    logic [31:0] par_a, par_b, exp_q;
    logic [15:0] cap_q = 16'h0000;
    int bad_count = 0, n_checks = 0;
    ssp_if lnk();
    ssp_if lnk_b();

    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge lnk.sclk) cap_q <= {cap_q[14:0], lnk.sdio};

    ssp_host u_ssp_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(lnk.host), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i), .resync_i(resync_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
    ssp_device #(.TXN_TIMEOUT(TMO), .PRODUCT_ID(PID)) u_ssp_device (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .link(lnk.dev), .motion_x_i(mx), .motion_y_i(my), .param_o(par_a));
    ssp_device #(.TXN_TIMEOUT(TMO), .PRODUCT_ID(PID)) u_ssp_device_b (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .link(lnk_b.dev), .motion_x_i(mx), .motion_y_i(my), .param_o(par_b));
    ssp_chk u_ssp_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk(lnk.sclk),
        .power_down_pin(lnk.power_down_pin), .sdio_host_o(lnk.sdio_host_o), .sdio_host_oe(lnk.sdio_host_oe),
        .sdio_dev_o(lnk.sdio_dev_o), .sdio_dev_oe(lnk.sdio_dev_oe));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        chk("ready wait", n < 3000, 1);
    endtask
    // one frame; the wire capture also proves msb-first order and the lead bit
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        wait_ready();
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_data_i = d;
        tick(1);
        req_valid_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        q = rsp_data_o;
        chk("response wait", n < 3000, 1);
        // for a read, d carries the value the device should return
        chk("wire frame", cap_q, {wr, a, d});
        if (wr) begin
            chk("write response", q, 8'h00);
            chk("line after write", lnk.sdio_dev_oe, 1'b0);
        end
        // the host must not offer the next request inside the gap
        tick(wr ? WRITE_GAP_CYC - 2 : READ_GAP_CYC - 1);
        chk("command gap", req_ready_o, 1'b0);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, a, exp, q);
        chk("read data", q, exp);
    endtask
    // hand-driven host on the second link, half period of 5 cycles
    task automatic bang(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            lnk_b.sclk = 1'b0;
            lnk_b.sdio_host_o = v[15-i];
            lnk_b.sdio_host_oe = 1'b1;
            tick(5);
            lnk_b.sclk = 1'b1;
            tick(5);
        end
        lnk_b.sdio_host_oe = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_params();
        logic [7:0] q;
        for (int i = 0; i < PARAM_NUM; i++) begin
            exp_q[8*i +: 8] = 8'hA5 ^ 8'(i * 17);
            xfer(1'b1, ADDR_PARAM_BASE + 7'(i), exp_q[8*i +: 8], q);
        end
        chk("params", par_a, exp_q);
        for (int i = 0; i < PARAM_NUM; i++) begin
            rd(ADDR_PARAM_BASE + 7'(i), exp_q[8*i +: 8]);
        end
    endtask
    task automatic t_unmapped();
        logic [7:0] q;
        xfer(1'b1, 7'h14, 8'h3E, q);
        xfer(1'b1, 7'h7F, 8'h81, q);
        chk("params kept", par_a, exp_q);
        rd(7'h14, 8'h00);
        rd(ADDR_MOTION_X, 8'hC3);
        rd(ADDR_MOTION_Y, 8'h1E);
    endtask
    task automatic t_resync();
        rd(ADDR_PRODUCT, PID);
        // product id ends in 0, so the held bit differs from the pull-up
        chk("d0 held", {lnk.sdio_dev_oe, lnk.sdio}, 2'b10);
        wait_ready();
        resync_i = 1'b1;
        tick(1);
        resync_i = 1'b0;
        tick(20);
        chk("pd high", lnk.power_down_pin, 1'b1);
        chk("line free", lnk.sdio_dev_oe, 1'b0);
        rd(ADDR_PARAM_BASE + 7'h01, exp_q[15:8]);
    endtask
    task automatic t_abort();
        bang({1'b1, 7'h11, 8'hEE}, 10);
        lnk_b.power_down_pin = 1'b1;
        tick(PD_PULSE_CYC);
        lnk_b.power_down_pin = 1'b0;
        tick(5);
        chk("aborted write", par_b, 32'h0000_0000);
        bang({1'b1, 7'h12, 8'h77}, 16);
        tick(10);
        chk("write after pd", par_b, 32'h0077_0000);
        tick(WRITE_GAP_CYC);
    endtask
    task automatic t_timeout();
        bang({1'b1, 7'h10, 8'h00}, 8);
        tick(TMO + 500);
        bang({1'b1, 7'h13, 8'h42}, 16);
        tick(10);
        chk("write after stall", par_b, 32'h4277_0000);
    endtask

    initial begin
        lnk_b.sclk = 1'b1;
        lnk_b.power_down_pin = 1'b0;
        lnk_b.sdio_host_o = 1'b0;
        lnk_b.sdio_host_oe = 1'b0;
        // a clean rising edge on reset, so every async reset branch runs
        #1;
        sys_rst_i = 1'b1;
        tick(5);
        sys_rst_i = 1'b0;
        tick(4);
        t_params();
        t_unmapped();
        t_resync();
        t_abort();
        t_timeout();
        complete_run();
    end

    // about twice the expected run
    initial begin
        #5_000_000;
        bad_count++;
        complete_run();
    end
endmodule
